// ---- cho_option_low.sv ----
/*
 * Charger option low-byte register with its serial-bus target and side effects.
 * Assumes scl/sda, comparator and presence pins are asynchronous; other inputs share clk_sys.
 */
`timescale 1ns/1ps
module cho_option_low (
    input  wire logic               clk_sys,
    input  wire logic               srst,
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe_n,
    input  wire logic               comparator_raw,
    input  wire logic               battery_presence_pin,
    input  wire logic               auto_regulation_disable_option,
    input  wire logic               comparator_profile_enable,
    input  wire logic               status_read_pulse,
    input  wire logic               charger_regulation_off,
    input  wire logic               charge_values_valid,
    input  wire logic               battery_below_min_sys,
    input  wire logic               single_cell,
    input  wire logic               battery_below_3v0,
    output cho_pkg::cho_ctrl_s      ctrl,
    output logic                    comparator_output_pin,
    output logic                    comparator_status_flag,
    output logic                    charge_enable,
    output logic                    battery_switch_full_on,
    output cho_pkg::cho_clamp_e     precharge_clamp
);

    // ==========================================================
    // Input synchronisers: scl, sda, comparator, presence
    logic [3:0]          sync1_ff;
    logic [3:0]          sync2_ff;
    logic [3:0]          last_ff;
    logic                scl_s;
    logic                sda_s;
    logic                cmp_s;
    logic                pres_s;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sync1_ff <= 4'hF;
            sync2_ff <= 4'hF;
            last_ff  <= 4'hF;
        end
        else
        begin
            sync1_ff <= {battery_presence_pin, comparator_raw, sda_in, scl_in};
            sync2_ff <= sync1_ff;
            last_ff  <= sync2_ff;
        end
    end

    assign scl_s  = sync2_ff[0];
    assign sda_s  = sync2_ff[1];
    assign cmp_s  = sync2_ff[2];
    assign pres_s = sync2_ff[3];

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic pres_fall;
    logic cmp_fall;

    assign scl_rise  = scl_s & ~last_ff[0];
    assign scl_fall  = ~scl_s & last_ff[0];
    assign bus_start = scl_s & last_ff[0] & last_ff[1] & ~sda_s;
    assign bus_stop  = scl_s & last_ff[0] & ~last_ff[1] & sda_s;
    assign pres_fall = last_ff[3] & ~pres_s;
    assign cmp_fall  = last_ff[2] & ~cmp_s;

    // ==========================================================
    // Serial target state machine
    cho_pkg::cho_state_e state_ff;
    logic [3:0]          bitcnt_ff;
    logic [7:0]          shreg_ff;
    logic [7:0]          cmd_ff;
    logic [7:0]          txsh_ff;
    logic                drive_low_ff;
    logic                host_ack_ff;
    logic                commit;
    logic [7:0]          rd_byte;

    assign commit  = scl_fall && state_ff == cho_pkg::CHO_ST_WACK
                     && cmd_ff == cho_pkg::CHO_CMD_OPTION_LOW;  // R16
    assign rd_byte = (cmd_ff == cho_pkg::CHO_CMD_OPTION_LOW) ? ctrl : cho_pkg::CHO_READ_UNMAPPED;  // R1

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_ff     <= cho_pkg::CHO_ST_IDLE;
            bitcnt_ff    <= 4'h0;
            shreg_ff     <= 8'h00;
            cmd_ff       <= 8'hFF;
            txsh_ff      <= 8'h00;
            drive_low_ff <= 1'b0;
            host_ack_ff  <= 1'b0;
        end
        else if (bus_start)
        begin
            state_ff     <= cho_pkg::CHO_ST_ADDR;
            bitcnt_ff    <= 4'h0;
            drive_low_ff <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_ff     <= cho_pkg::CHO_ST_IDLE;
            drive_low_ff <= 1'b0;
        end
        else if (scl_rise)
        begin
            case (state_ff)
                cho_pkg::CHO_ST_ADDR, cho_pkg::CHO_ST_CMD, cho_pkg::CHO_ST_WDATA:
                begin
                    shreg_ff  <= {shreg_ff[6:0], sda_s};
                    bitcnt_ff <= bitcnt_ff + 4'h1;
                end
                cho_pkg::CHO_ST_RDATA:
                    bitcnt_ff <= bitcnt_ff + 4'h1;
                cho_pkg::CHO_ST_RACK:
                    host_ack_ff <= ~sda_s;
                default:
                    bitcnt_ff <= bitcnt_ff;
            endcase
        end
        else if (scl_fall)
        begin
            case (state_ff)
                cho_pkg::CHO_ST_ADDR:
                begin
                    if (bitcnt_ff == cho_pkg::CHO_BITS_PER_BYTE)
                    begin
                        if (shreg_ff[7:1] == cho_pkg::CHO_I2C_ADDR)
                        begin
                            state_ff     <= cho_pkg::CHO_ST_AACK;
                            drive_low_ff <= 1'b1;
                        end
                        else
                            state_ff <= cho_pkg::CHO_ST_IDLE;
                    end
                end
                cho_pkg::CHO_ST_CMD, cho_pkg::CHO_ST_WDATA:
                begin
                    if (bitcnt_ff == cho_pkg::CHO_BITS_PER_BYTE)
                    begin
                        state_ff     <= (state_ff == cho_pkg::CHO_ST_CMD) ? cho_pkg::CHO_ST_CACK
                                                                          : cho_pkg::CHO_ST_WACK;
                        drive_low_ff <= 1'b1;
                        if (state_ff == cho_pkg::CHO_ST_CMD)
                            cmd_ff <= shreg_ff;
                    end
                end
                cho_pkg::CHO_ST_AACK:
                begin
                    bitcnt_ff <= 4'h0;
                    if (shreg_ff[0])
                    begin
                        state_ff     <= cho_pkg::CHO_ST_RDATA;
                        txsh_ff      <= {rd_byte[6:0], 1'b0};
                        drive_low_ff <= ~rd_byte[7];
                    end
                    else
                    begin
                        state_ff     <= cho_pkg::CHO_ST_CMD;
                        drive_low_ff <= 1'b0;
                    end
                end
                cho_pkg::CHO_ST_CACK, cho_pkg::CHO_ST_WACK:
                begin
                    state_ff     <= cho_pkg::CHO_ST_WDATA;
                    bitcnt_ff    <= 4'h0;
                    drive_low_ff <= 1'b0;
                end
                cho_pkg::CHO_ST_RDATA:
                begin
                    if (bitcnt_ff == cho_pkg::CHO_BITS_PER_BYTE)
                    begin
                        state_ff     <= cho_pkg::CHO_ST_RACK;
                        drive_low_ff <= 1'b0;
                    end
                    else
                    begin
                        drive_low_ff <= ~txsh_ff[7];
                        txsh_ff      <= {txsh_ff[6:0], 1'b0};
                    end
                end
                cho_pkg::CHO_ST_RACK:
                begin
                    bitcnt_ff <= 4'h0;
                    if (host_ack_ff)
                    begin
                        state_ff     <= cho_pkg::CHO_ST_RDATA;
                        txsh_ff      <= {rd_byte[6:0], 1'b0};
                        drive_low_ff <= ~rd_byte[7];
                    end
                    else
                        state_ff <= cho_pkg::CHO_ST_IDLE;
                end
                default:
                    state_ff <= cho_pkg::CHO_ST_IDLE;
            endcase
        end
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drive_low_ff;

    // ==========================================================
    // Option register
    logic reg_clr;
    logic latch_toggle;

    assign reg_clr      = charger_regulation_off | (auto_regulation_disable_option & pres_fall);  // R13 R15
    assign latch_toggle = commit && shreg_ff[cho_pkg::CHO_BIT_CMP_LATCH] != ctrl.comparator_latch_enable;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            ctrl <= cho_pkg::CHO_RESET_VALUE;
        else
        begin
            if (commit)
                ctrl <= shreg_ff;  // R1 R5 R6 R8 R9 R12 R14 R16
            if (reg_clr)
                ctrl.input_current_regulation_enable <= 1'b0;  // R13 R15
        end
    end

    // ==========================================================
    // Comparator output and status flag
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            comparator_output_pin  <= 1'b1;
            comparator_status_flag <= 1'b0;
        end
        else
        begin
            if (latch_toggle)
                comparator_output_pin <= 1'b1;  // R3
            else if (ctrl.comparator_latch_enable)
                comparator_output_pin <= comparator_output_pin & cmp_s;  // R2
            else
                comparator_output_pin <= cmp_s;  // R2
            if (ctrl.comparator_latch_enable && comparator_profile_enable)
                comparator_status_flag <= cmp_fall | (comparator_status_flag & ~status_read_pulse);  // R4
            else
                comparator_status_flag <= ~cmp_s;
        end
    end

    // ==========================================================
    // Charge path controls
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            charge_enable          <= 1'b0;
            battery_switch_full_on <= 1'b0;
            precharge_clamp        <= cho_pkg::CHO_CLAMP_NONE;
        end
        else
        begin
            charge_enable          <= ~ctrl.charging_block & charge_values_valid;  // R14
            battery_switch_full_on <= ~ctrl.precharge_linear_enable;  // R11
            if (!ctrl.precharge_linear_enable || !battery_below_min_sys)
                precharge_clamp <= cho_pkg::CHO_CLAMP_NONE;
            else if (single_cell && !battery_below_3v0)
                precharge_clamp <= cho_pkg::CHO_CLAMP_2A;  // R10
            else
                precharge_clamp <= cho_pkg::CHO_CLAMP_384MA;  // R10
        end
    end

    // ==========================================================
    // Assertions
    property p_commit_data;
        @(posedge clk_sys) disable iff (srst)
        commit |=> ctrl[7:2] == $past(shreg_ff[7:2]) && ctrl[0] == $past(shreg_ff[0]);
    endproperty
    a_commit_data: assert property (p_commit_data) else $error("write data not stored");  // R1

    property p_only_on_commit;
        @(posedge clk_sys) disable iff (srst)
        !$stable(ctrl) |-> $past(commit || reg_clr);
    endproperty
    a_only_on_commit: assert property (p_only_on_commit) else $error("register changed mid transfer");  // R16

    property p_latch_hold;
        @(posedge clk_sys) disable iff (srst)
        ctrl.comparator_latch_enable && !comparator_output_pin && !latch_toggle ##1 !commit [*2]
        |-> !comparator_output_pin;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched output released");  // R2

    property p_follow;
        @(posedge clk_sys) disable iff (srst)
        !ctrl.comparator_latch_enable && !latch_toggle |=> comparator_output_pin == $past(cmp_s);
    endproperty
    a_follow: assert property (p_follow) else $error("output not following comparator");  // R2

    property p_toggle_release;
        @(posedge clk_sys) disable iff (srst)
        latch_toggle |=> comparator_output_pin;
    endproperty
    a_toggle_release: assert property (p_toggle_release) else $error("toggle did not release pin");  // R3

    property p_flag_sticky;
        @(posedge clk_sys) disable iff (srst)
        comparator_status_flag && ctrl.comparator_latch_enable && comparator_profile_enable
        && !status_read_pulse |=> comparator_status_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("status flag lost before read");  // R4

    property p_auto_clear;
        @(posedge clk_sys) disable iff (srst)
        auto_regulation_disable_option && pres_fall |=> !ctrl.input_current_regulation_enable;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("regulation not auto cleared");  // R15

    property p_charger_clear;
        @(posedge clk_sys) disable iff (srst)
        charger_regulation_off |=> !ctrl.input_current_regulation_enable ##1 1'b1;
    endproperty
    a_charger_clear: assert property (p_charger_clear) else $error("regulation enable not cleared");  // R13

    property p_inhibit;
        @(posedge clk_sys) disable iff (srst)
        ctrl.charging_block |=> !charge_enable;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("charging while inhibited");  // R14

    property p_clamp;
        @(posedge clk_sys) disable iff (srst)
        ctrl.precharge_linear_enable && battery_below_min_sys |=> precharge_clamp != cho_pkg::CHO_CLAMP_NONE;
    endproperty
    a_clamp: assert property (p_clamp) else $error("precharge not clamped");  // R10

    c_write: cover property (@(posedge clk_sys) disable iff (srst) commit);
    c_release: cover property (@(posedge clk_sys) disable iff (srst) !comparator_output_pin ##1 latch_toggle);
    c_flag_read: cover property (@(posedge clk_sys) disable iff (srst) comparator_status_flag ##1 status_read_pulse);

endmodule

// ---- cho_pkg.sv ----
/*
 * Constants, types and state codes for the charger option low-byte register block.
 * Assumes one 50 MHz clock and a synchronous active-high reset.
 */
//
// Behaviour
// R1: Command byte 00h over the serial bus selects this eight-bit option register.
// R2: Bit 7 set latches a low comparator output; clear lets it follow.
// R3: Toggling bit 7 while latched releases the comparator output pin.
// R4: Latched with profile enabled, the status flag holds until host reads it.
// R5: Bit 6 zero keeps undervoltage protection on; one disables it.
// R6: Bit 5 set enters learn mode; converter off, battery discharges.
// R7: Host writes learn bit back to zero when battery nears depletion.
// R8: Bit 4 selects input-current monitor gain, 20 or 40 times.
// R9: Bit 3 selects battery-current monitor gain, 8 or 16 times.
// R10: Linear precharge below minimum voltage clamps current at 384 mA or 2A.
// R11: Linear precharge disabled drives the battery switch fully on.
// R12: Bit 1 enables input-current regulation; host may write it back on.
// R13: Charger clearing regulation makes bit 1 read back zero.
// R14: Bit 0 zero allows charging with valid values; one inhibits charging.
// R15: Auto option set and presence pin falling clears regulation enable.
// R16: Written value takes effect only after the data byte is acknowledged.
package cho_pkg;

    // ==========================================================
    // Register map and reset
    localparam logic [7:0] CHO_CMD_OPTION_LOW = 8'h00;
    localparam logic [7:0] CHO_RESET_VALUE    = 8'h0E;
    localparam logic [6:0] CHO_I2C_ADDR       = 7'h09;  // Arbitrary bus address
    localparam logic [7:0] CHO_READ_UNMAPPED  = 8'h00;
    localparam logic [3:0] CHO_BITS_PER_BYTE  = 4'h8;

    // ==========================================================
    // Field positions
    localparam int CHO_BIT_CMP_LATCH = 7;
    localparam int CHO_BIT_UVP_DIS   = 6;
    localparam int CHO_BIT_LEARN     = 5;
    localparam int CHO_BIT_IIN_GAIN  = 4;
    localparam int CHO_BIT_BAT_GAIN  = 3;
    localparam int CHO_BIT_LINEAR    = 2;
    localparam int CHO_BIT_IIN_REG   = 1;
    localparam int CHO_BIT_BLOCK     = 0;

    // ==========================================================
    // Types
    typedef struct packed {
        logic comparator_latch_enable;
        logic system_undervoltage_protect_disable;
        logic battery_learn_enable;
        logic input_current_monitor_gain;
        logic battery_current_monitor_gain;
        logic precharge_linear_enable;
        logic input_current_regulation_enable;
        logic charging_block;
    } cho_ctrl_s;

    typedef enum logic [1:0] {
        CHO_CLAMP_NONE  = 2'b00,
        CHO_CLAMP_384MA = 2'b01,
        CHO_CLAMP_2A    = 2'b10
    } cho_clamp_e;

    typedef enum logic [3:0] {
        CHO_ST_IDLE  = 4'b0000,
        CHO_ST_ADDR  = 4'b0001,
        CHO_ST_AACK  = 4'b0010,
        CHO_ST_CMD   = 4'b0011,
        CHO_ST_CACK  = 4'b0100,
        CHO_ST_WDATA = 4'b0101,
        CHO_ST_WACK  = 4'b0110,
        CHO_ST_RDATA = 4'b0111,
        CHO_ST_RACK  = 4'b1000
    } cho_state_e;

endpackage

// ---- cho_host_model.sv ----
/*
 * Serial-bus controller model that reaches the option register from the host side.
 * Assumes a pulled-up data line resolved by the bench and a 50 MHz clk_sys.
 */
`timescale 1ns/1ps
module cho_host_model (
    input  wire logic clk_sys,
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_line
);
    // ==========================================================
    // Bit and byte framing, half period of 10 clocks
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic w(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic bit_cyc(input logic b, output logic r);
        w(4);
        sda_drv = b;
        w(6);
        scl = 1'b1;
        w(10);
        r = sda_line;
        scl = 1'b0;
    endtask

    task automatic start_cond();
        w(4);
        sda_drv = 1'b1;
        w(6);
        scl = 1'b1;
        w(10);
        sda_drv = 1'b0;
        w(10);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        w(4);
        sda_drv = 1'b0;
        w(6);
        scl = 1'b1;
        w(10);
        sda_drv = 1'b1;
        w(10);
    endtask

    task automatic send_byte(input logic [7:0] v, output logic ok);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_cyc(v[i], r);
        bit_cyc(1'b1, r);
        ok = ~r;
    endtask

    task automatic recv_byte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_cyc(1'b1, d[i]);
        bit_cyc(1'b1, r);
    endtask

    // ==========================================================
    // Register transfers
    task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data, output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({cho_pkg::CHO_I2C_ADDR, 1'b0}, a0);
        send_byte(cmd, a1);
        send_byte(data, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask

    task automatic read_reg(input logic [7:0] cmd, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({cho_pkg::CHO_I2C_ADDR, 1'b0}, a0);
        send_byte(cmd, a1);
        start_cond();
        send_byte({cho_pkg::CHO_I2C_ADDR, 1'b1}, a2);
        recv_byte(d);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
endmodule

// ---- tb.sv ----
/*
 * Self-checking bench for the charger option low-byte register.
 * Assumes the host model above and a pull-up on the data line.
 */
`timescale 1ns/1ps
module tb;
    logic               clk_sys = 1'b0;
    logic               srst = 1'b1;
    logic               scl, sda_drv, sda_line, sda_out, sda_oe_n, ok;
    logic               cmp_raw = 1'b1, pres = 1'b1, auto_opt = 1'b0, prof = 1'b0;
    logic               rd_pulse = 1'b0, reg_off = 1'b0, valid = 1'b1;
    logic               below_min = 1'b0, one_cell = 1'b0, below_3v0 = 1'b0;
    logic               cmp_pin, stat_flag, chg_en, sw_on;
    logic [7:0]         rd;
    cho_pkg::cho_ctrl_s ctrl;
    cho_pkg::cho_clamp_e clamp;
    int                 n_fail = 0;
    int                 checks_done = 0;

    always #10 clk_sys = ~clk_sys;
    assign sda_line = sda_drv & (sda_oe_n | sda_out);

    cho_host_model host_u (.clk_sys(clk_sys), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

    cho_option_low dut_u (
        .clk_sys(clk_sys), .srst(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .comparator_raw(cmp_raw), .battery_presence_pin(pres),
        .auto_regulation_disable_option(auto_opt), .comparator_profile_enable(prof),
        .status_read_pulse(rd_pulse), .charger_regulation_off(reg_off), .charge_values_valid(valid),
        .battery_below_min_sys(below_min), .single_cell(one_cell), .battery_below_3v0(below_3v0),
        .ctrl(ctrl), .comparator_output_pin(cmp_pin), .comparator_status_flag(stat_flag),
        .charge_enable(chg_en), .battery_switch_full_on(sw_on), .precharge_clamp(clamp)
    );

    // ==========================================================
    // Helpers
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        host_u.write_reg(cmd, data, ok);
        chk("write_ack", {7'h0, ok}, 8'h01);
    endtask

    task automatic rdx(input logic [7:0] cmd);
        host_u.read_reg(cmd, rd, ok);
        chk("read_ack", {7'h0, ok}, 8'h01);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (90000) @(posedge clk_sys);
        n_fail++;
        report_and_stop();
    end

    // ==========================================================
    // Tests
    initial
    begin
        tick(10);
        srst = 1'b0;
        tick(4);
        chk("ctrl_reset", ctrl, 8'h0E);
        rdx(8'h00);
        chk("read_reset", rd, 8'h0E);
        $display("test reset done");

        host_u.start_cond();
        host_u.send_byte({cho_pkg::CHO_I2C_ADDR, 1'b0}, ok);
        host_u.send_byte(8'h00, ok);
        chk("ctrl_before_data", ctrl, 8'h0E);
        host_u.send_byte(8'hF1, ok);
        tick(6);
        chk("ctrl_after_ack", ctrl, 8'hF1);
        host_u.stop_cond();
        $display("test commit done");

        for (int i = 0; i < 8; i++)
        begin
            wr(8'h00, 8'h01 << i);
            chk("ctrl_field", ctrl, 8'h01 << i);
            chk("charge_enable", {7'h0, chg_en}, {7'h0, i != 0});
            chk("switch_on", {7'h0, sw_on}, {7'h0, i != 2});
            rdx(8'h00);
            chk("read_field", rd, 8'h01 << i);
        end
        wr(8'h01, 8'hFF);
        chk("ctrl_other_cmd", ctrl, 8'h80);
        rdx(8'h01);
        chk("read_other_cmd", rd, cho_pkg::CHO_READ_UNMAPPED);
        $display("test fields done");

        wr(8'h00, 8'h00);
        cmp_raw = 1'b0;
        tick(5);
        chk("cmp_follow_low", {7'h0, cmp_pin}, 8'h00);
        cmp_raw = 1'b1;
        tick(5);
        chk("cmp_follow_high", {7'h0, cmp_pin}, 8'h01);
        wr(8'h00, 8'h80);
        prof = 1'b1;
        cmp_raw = 1'b0;
        tick(5);
        cmp_raw = 1'b1;
        tick(5);
        chk("cmp_latched", {7'h0, cmp_pin}, 8'h00);
        chk("flag_held", {7'h0, stat_flag}, 8'h01);
        rd_pulse = 1'b1;
        tick(1);
        rd_pulse = 1'b0;
        tick(3);
        chk("flag_cleared", {7'h0, stat_flag}, 8'h00);
        wr(8'h00, 8'h00);
        chk("cmp_released", {7'h0, cmp_pin}, 8'h01);
        $display("test comparator done");

        wr(8'h00, 8'h02);
        reg_off = 1'b1;
        tick(1);
        reg_off = 1'b0;
        tick(3);
        chk("reg_hw_clear", ctrl, 8'h00);
        rdx(8'h00);
        chk("read_hw_clear", rd, 8'h00);
        wr(8'h00, 8'h02);
        chk("reg_host_set", ctrl, 8'h02);
        auto_opt = 1'b1;
        pres = 1'b0;
        tick(6);
        chk("reg_auto_clear", ctrl, 8'h00);
        pres = 1'b1;
        auto_opt = 1'b0;
        $display("test regulation done");

        wr(8'h00, 8'h04);
        below_min = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            one_cell = (k != 0);
            below_3v0 = (k == 1);
            tick(3);
            chk("clamp", {6'h0, clamp}, (k == 2) ? 8'h02 : 8'h01);
        end
        chk("switch_linear", {7'h0, sw_on}, 8'h00);
        wr(8'h00, 8'h00);
        chk("switch_full", {7'h0, sw_on}, 8'h01);
        $display("test precharge done");

        srst = 1'b1;
        tick(3);
        srst = 1'b0;
        tick(4);
        chk("ctrl_rereset", ctrl, 8'h0E);
        chk("clamp_rereset", {6'h0, clamp}, 8'h02);
        chk("switch_rereset", {7'h0, sw_on}, 8'h00);
        chk("charge_on", {7'h0, chg_en}, 8'h01);
        below_min = 1'b0;
        valid = 1'b0;
        tick(3);
        chk("clamp_off", {6'h0, clamp}, 8'h00);
        chk("charge_invalid", {7'h0, chg_en}, 8'h00);
        valid = 1'b1;
        rdx(8'h00);
        chk("read_rereset", rd, 8'h0E);
        $display("test mid reset done");
        report_and_stop();
    end
endmodule
